// File: shared/serial_flash_defs.vh
// Purpose: constants for the serial flash command engine
// Assumes: ref_clk at 10 MHz, 18-bit array address (top_address_bit 17)
// Notes:   self-timed durations are plain defaults, counts derive in the engine
`ifndef SERIAL_FLASH_DEFS_VH
`define SERIAL_FLASH_DEFS_VH

// instruction codes
`define OP_READ       8'h03
`define OP_PROG       8'h02
`define OP_AUTO_PROG  8'hAF
`define OP_SECT_ERASE 8'h20
`define OP_BLK_ERASE  8'h52
`define OP_CHIP_ERASE 8'h60
`define OP_STAT_RD    8'h05
`define OP_STAT_ARM   8'h50
`define OP_STAT_WR    8'h01
`define OP_SET_LATCH  8'h06
`define OP_CLR_LATCH  8'h04
`define OP_ID_RD      8'h90
`define OP_ID_RD_ALT  8'hAB

// array geometry
`define ADDR_W        18
`define ADDR_TOP      18'h3FFFF
`define QUARTER_BASE  18'h30000
`define HALF_BASE     18'h20000

// erase kinds on the memory port
`define ERASE_SECTOR  2'h0
`define ERASE_BLOCK   2'h1
`define ERASE_CHIP    2'h2

// reset values
`define PROT_LEVEL_RST 2'h3
`define PROT_LOCK_RST  1'h0

// identification bytes, values arbitrary
`define MAKER_CODE    8'h5A
`define PART_CODE     8'hA5

// timing, microseconds, and clock rate
`define REF_CLK_MHZ        21'h0000A
`define BYTE_PROG_TIME_US  21'h00014
`define SECT_ERASE_TIME_US 21'h061A8
`define BLK_ERASE_TIME_US  21'h061A8
`define CHIP_ERASE_TIME_US 21'h186A0
`define TMR_W              21

`endif

// File: src/serial_flash_command_engine.v
// Purpose: instruction decoder and write control of a serial flash
// Assumes: link pins asynchronous to ref_clk; array behind a memory port
// Notes:   read data must be valid on mem_rdata one cycle after mem_rd
`timescale 1ns/1ps
`default_nettype none
`include "serial_flash_defs.vh"

module serial_flash_command_engine #(
    parameter [`TMR_W-1:0] BYTE_PROG_CYC  = `BYTE_PROG_TIME_US * `REF_CLK_MHZ,
    parameter [`TMR_W-1:0] SECT_ERASE_CYC = `SECT_ERASE_TIME_US * `REF_CLK_MHZ,
    parameter [`TMR_W-1:0] BLK_ERASE_CYC  = `BLK_ERASE_TIME_US * `REF_CLK_MHZ,
    parameter [`TMR_W-1:0] CHIP_ERASE_CYC = `CHIP_ERASE_TIME_US * `REF_CLK_MHZ
) (
    // clock, reset, enable
    input  wire               ref_clk,
    input  wire               rst_n,
    input  wire               clk_en,
    // serial link pins
    input  wire               cs_n,
    input  wire               sck,
    input  wire               si,
    input  wire               write_protect_n,
    output wire               so_out,
    output wire               so_oe,
    // array port
    output wire [`ADDR_W-1:0] mem_addr,
    output wire [7:0]         mem_wdata,
    output wire               mem_rd,
    input  wire [7:0]         mem_rdata,
    output wire               mem_prog,
    output wire               mem_erase,
    output wire [1:0]         mem_erase_kind,
    // status bits
    output wire               busy,
    output wire               write_enable_latch,
    output wire               auto_increment_program,
    output wire [1:0]         protect_level,
    output wire               protect_lock
);

// ----------------------------------------------------------------
// states and helpers
// ----------------------------------------------------------------
localparam [1:0] ST_CMD = 2'h0;
localparam [1:0] ST_IN  = 2'h1;
localparam [1:0] ST_OUT = 2'h2;
localparam [1:0] ST_IGN = 2'h3;

// address inside the protected region for a level
function prot_hit;
    input [`ADDR_W-1:0] a;
    input [1:0]         lvl;
    begin
        case (lvl)
            2'h0:    prot_hit = 1'b0;
            2'h1:    prot_hit = (a >= `QUARTER_BASE);
            2'h2:    prot_hit = (a >= `HALF_BASE);
            default: prot_hit = 1'b1;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg  [2:0]         cs_sy, sck_sy, bit_q, byte_q;
reg  [1:0]         si_sy, wp_sy, st_q, bp_q, kind_q;
reg  [7:0]         sr_q, cmd_q, data_q, out_q, mem_wd_q;
reg  [23:0]        addr_q;
reg  [`ADDR_W-1:0] aai_ptr_q, mem_a_q;
reg  [`TMR_W-1:0]  tmr_q;
reg                so_q, oe_q, cmpl_q, id_sel_q, fetch_q, arm_q, wel_q;
reg                aai_q, bpl_q, busy_q, mem_rd_q, mem_prog_q, mem_erase_q;

// ----------------------------------------------------------------
// link edges and derived values
// ----------------------------------------------------------------
wire               cs_lo    = ~cs_sy[1];
wire               cs_rise  = cs_sy[1] & ~cs_sy[2];
wire               cs_fall  = ~cs_sy[1] & cs_sy[2];
wire               sck_rise = cs_lo & sck_sy[1] & ~sck_sy[2];
wire               sck_fall = cs_lo & ~sck_sy[1] & sck_sy[2];
wire [7:0]         in_byte  = {sr_q[6:0], si_sy[1]};
wire               byte_end = sck_rise & (bit_q == 3'h7);
wire [`ADDR_W-1:0] addr_a   = addr_q[`ADDR_W-1:0];
wire [`ADDR_W-1:0] aai_tgt  = aai_q ? aai_ptr_q : addr_a;
wire [`ADDR_W-1:0] aai_next = aai_ptr_q + 18'h00001;
wire               locked   = ~wp_sy[1] & bpl_q;
wire               can_wr   = wel_q & ~busy_q;
wire [7:0]         status   = {bpl_q, aai_q, 2'h0, bp_q, wel_q, busy_q};

// ----------------------------------------------------------------
// pin synchronisers, edge history on the third stage
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        cs_sy  <= 3'h7;
        sck_sy <= 3'h0;
        si_sy  <= 2'h0;
        wp_sy  <= 2'h3;
    end else if (clk_en) begin
        cs_sy  <= {cs_sy[1:0], cs_n};
        sck_sy <= {sck_sy[1:0], sck};
        si_sy  <= {si_sy[0], si};
        wp_sy  <= {wp_sy[0], write_protect_n};
    end
end

// ----------------------------------------------------------------
// instruction engine
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        st_q        <= ST_CMD;
        bit_q       <= 3'h0;
        byte_q      <= 3'h0;
        sr_q        <= 8'h00;
        cmd_q       <= 8'h00;
        addr_q      <= 24'h000000;
        data_q      <= 8'h00;
        out_q       <= 8'hFF;
        so_q        <= 1'b0;
        oe_q        <= 1'b0;
        cmpl_q      <= 1'b0;
        id_sel_q    <= 1'b0;
        fetch_q     <= 1'b0;
        arm_q       <= 1'b0;
        wel_q       <= 1'b0;
        aai_q       <= 1'b0;
        aai_ptr_q   <= 18'h00000;
        bp_q        <= `PROT_LEVEL_RST;
        bpl_q       <= `PROT_LOCK_RST;
        busy_q      <= 1'b0;
        tmr_q       <= 21'h000000;
        mem_a_q     <= 18'h00000;
        mem_wd_q    <= 8'hFF;
        mem_rd_q    <= 1'b0;
        mem_prog_q  <= 1'b0;
        mem_erase_q <= 1'b0;
        kind_q      <= `ERASE_SECTOR;
    end else if (clk_en) begin
        mem_rd_q    <= 1'b0;
        mem_prog_q  <= 1'b0;
        mem_erase_q <= 1'b0;
        fetch_q     <= mem_rd_q;
        oe_q        <= cs_lo & (st_q == ST_OUT);
        // self-timed operation countdown
        if (busy_q) begin
            if (tmr_q == 21'h000000) begin
                busy_q <= 1'b0;
                if (!aai_q) begin
                    wel_q <= 1'b0;
                end else begin
                    aai_ptr_q <= aai_next;
                    if (aai_ptr_q == `ADDR_TOP || prot_hit(aai_next, bp_q)) begin
                        aai_q <= 1'b0;
                        wel_q <= 1'b0;
                    end
                end
            end else begin
                tmr_q <= tmr_q - 21'h000001;
            end
        end
        // new instruction frame
        if (cs_fall) begin
            st_q   <= ST_CMD;
            bit_q  <= 3'h0;
            byte_q <= 3'h0;
            cmpl_q <= 1'b0;
        end
        // input shift on rising serial clock, msb first
        if (sck_rise) begin
            sr_q  <= in_byte;
            bit_q <= bit_q + 3'h1;
        end
        // output shift on falling serial clock
        if (sck_fall && st_q == ST_OUT) begin
            so_q  <= out_q[7];
            out_q <= {out_q[6:0], 1'b1};
        end
        if (fetch_q) out_q <= mem_rdata;                        // next array byte
        // completed bus cycle
        if (byte_end) begin
            byte_q <= byte_q + 3'h1;
            case (st_q)
                ST_CMD: begin
                    cmd_q <= in_byte;
                    st_q  <= ST_IN;
                    if (busy_q && in_byte != `OP_STAT_RD) begin
                        st_q <= ST_IGN;
                    end else begin
                        case (in_byte)
                            `OP_STAT_RD: begin
                                st_q  <= ST_OUT;
                                out_q <= status;
                            end
                            `OP_SET_LATCH, `OP_CLR_LATCH,
                            `OP_STAT_ARM, `OP_CHIP_ERASE: begin
                                cmpl_q <= 1'b1;
                                st_q   <= ST_IGN;
                            end
                            `OP_AUTO_PROG: if (aai_q) byte_q <= 3'h4;
                            default: ;
                        endcase
                    end
                end
                ST_IN: begin
                    if (cmd_q == `OP_STAT_WR || byte_q == 3'h4) begin
                        data_q <= in_byte;
                        cmpl_q <= 1'b1;
                        st_q   <= ST_IGN;
                    end else begin
                        addr_q <= {addr_q[15:0], in_byte};
                    end
                    if (byte_q == 3'h3) begin
                        case (cmd_q)
                            `OP_READ: begin
                                st_q     <= ST_OUT;
                                mem_a_q  <= {addr_q[9:0], in_byte};
                                mem_rd_q <= 1'b1;
                            end
                            `OP_ID_RD, `OP_ID_RD_ALT: begin
                                st_q     <= ST_OUT;
                                id_sel_q <= in_byte[0];
                                out_q    <= in_byte[0] ? `PART_CODE : `MAKER_CODE;
                            end
                            `OP_SECT_ERASE, `OP_BLK_ERASE: begin
                                cmpl_q <= 1'b1;
                                st_q   <= ST_IGN;
                            end
                            default: ;
                        endcase
                    end
                end
                ST_OUT: begin
                    if (cmd_q == `OP_READ) begin
                        mem_a_q  <= mem_a_q + 18'h00001;
                        mem_rd_q <= 1'b1;
                    end else if (cmd_q == `OP_STAT_RD) begin
                        out_q <= status;
                    end else begin
                        id_sel_q <= ~id_sel_q;
                        out_q    <= id_sel_q ? `MAKER_CODE : `PART_CODE;
                    end
                end
                default: ;
            endcase
        end
        // end of frame: execute only a whole instruction
        if (cs_rise) begin
            st_q  <= ST_CMD;
            arm_q <= cmpl_q && bit_q == 3'h0 && cmd_q == `OP_STAT_ARM;
            if (cmpl_q && bit_q == 3'h0) begin
                case (cmd_q)
                    `OP_SET_LATCH: wel_q <= 1'b1;
                    `OP_CLR_LATCH: begin
                        wel_q <= 1'b0;
                        aai_q <= 1'b0;
                    end
                    `OP_STAT_WR: begin
                        if (arm_q && !locked) begin
                            bp_q  <= data_q[3:2];
                            bpl_q <= data_q[7];
                        end
                    end
                    `OP_PROG: begin
                        if (can_wr && !prot_hit(addr_a, bp_q)) begin
                            mem_a_q    <= addr_a;
                            mem_wd_q   <= data_q;
                            mem_prog_q <= 1'b1;
                            busy_q     <= 1'b1;
                            tmr_q      <= BYTE_PROG_CYC - 21'h000001;
                        end
                    end
                    `OP_AUTO_PROG: begin
                        if (can_wr && !prot_hit(aai_tgt, bp_q)) begin
                            aai_q      <= 1'b1;
                            aai_ptr_q  <= aai_tgt;
                            mem_a_q    <= aai_tgt;
                            mem_wd_q   <= data_q;
                            mem_prog_q <= 1'b1;
                            busy_q     <= 1'b1;
                            tmr_q      <= BYTE_PROG_CYC - 21'h000001;
                        end
                    end
                    `OP_SECT_ERASE: begin
                        if (can_wr && !prot_hit(addr_a, bp_q)) begin
                            mem_a_q     <= {addr_a[17:12], 12'h000};
                            kind_q      <= `ERASE_SECTOR;
                            mem_erase_q <= 1'b1;
                            busy_q      <= 1'b1;
                            tmr_q       <= SECT_ERASE_CYC - 21'h000001;
                        end
                    end
                    `OP_BLK_ERASE: begin
                        if (can_wr && !prot_hit(addr_a, bp_q)) begin
                            mem_a_q     <= {addr_a[17:15], 15'h0000};
                            kind_q      <= `ERASE_BLOCK;
                            mem_erase_q <= 1'b1;
                            busy_q      <= 1'b1;
                            tmr_q       <= BLK_ERASE_CYC - 21'h000001;
                        end
                    end
                    `OP_CHIP_ERASE: begin
                        if (can_wr && bp_q == 2'h0) begin
                            mem_a_q     <= 18'h00000;
                            kind_q      <= `ERASE_CHIP;
                            mem_erase_q <= 1'b1;
                            busy_q      <= 1'b1;
                            tmr_q       <= CHIP_ERASE_CYC - 21'h000001;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
end

// ----------------------------------------------------------------
// outputs
// ----------------------------------------------------------------
assign so_out                 = so_q;
assign so_oe                  = oe_q;
assign mem_addr               = mem_a_q;
assign mem_wdata              = mem_wd_q;
assign mem_rd                 = mem_rd_q;
assign mem_prog               = mem_prog_q;
assign mem_erase              = mem_erase_q;
assign mem_erase_kind         = kind_q;
assign busy                   = busy_q;
assign write_enable_latch     = wel_q;
assign auto_increment_program = aai_q;
assign protect_level          = bp_q;
assign protect_lock           = bpl_q;

endmodule // serial_flash_command_engine
`default_nettype wire

// File: test/flash_engine_props.sv
// Purpose: port checks for the flash command engine
// Assumes: clk_en held high
// Notes:   bound to the engine from tb
`timescale 1ns/1ps
`default_nettype none
`include "serial_flash_defs.vh"
module flash_engine_props #(
    parameter [`TMR_W-1:0] BYTE_PROG_CYC  = 20,
    parameter [`TMR_W-1:0] SECT_ERASE_CYC = 40,
    parameter [`TMR_W-1:0] BLK_ERASE_CYC  = 40,
    parameter [`TMR_W-1:0] CHIP_ERASE_CYC = 60
) (
    // clock, reset, pins
    input wire logic               ref_clk,
    input wire logic               rst_n,
    input wire logic               cs_n,
    input wire logic               write_protect_n,
    input wire logic               so_oe,
    // array port
    input wire logic [`ADDR_W-1:0] mem_addr,
    input wire logic               mem_prog,
    input wire logic               mem_erase,
    input wire logic [1:0]         mem_erase_kind,
    input wire logic [1:0]         protect_level,
    // status
    input wire logic               busy,
    input wire logic               write_enable_latch,
    input wire logic               protect_lock
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [`TMR_W-1:0] len_q, exp_q;
    // busy length counter and expected length per operation
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            len_q <= '0;
            exp_q <= '0;
        end else begin
            len_q <= busy ? len_q + 1'b1 : '0;
            if (mem_prog) exp_q <= BYTE_PROG_CYC;
            else if (mem_erase) exp_q <= (mem_erase_kind == `ERASE_CHIP) ? CHIP_ERASE_CYC :
                (mem_erase_kind == `ERASE_BLOCK) ? BLK_ERASE_CYC : SECT_ERASE_CYC;
        end
    end
    function automatic logic prot(input logic [`ADDR_W-1:0] a, input logic [1:0] l);
        prot = (l == 2'h3) || (l == 2'h2 && a >= `HALF_BASE) || (l == 2'h1 && a >= `QUARTER_BASE);
    endfunction
    a_prog_latch:
        assert property (mem_prog |-> $past(write_enable_latch)) else $error("program without latch");
    a_erase_latch:
        assert property (mem_erase |-> $past(write_enable_latch)) else $error("erase without latch");
    a_write_after_cs:
        assert property ((mem_prog || mem_erase) |-> cs_n && $past(cs_n, 2) && busy)
        else $error("write started while selected");
    a_busy_length:
        assert property ($fell(busy) |-> len_q == exp_q) else $error("busy length wrong");
    a_chip_open:
        assert property (mem_erase && mem_erase_kind == `ERASE_CHIP |-> protect_level == 2'h0)
        else $error("chip erase while protected");
    a_prog_open:
        assert property (mem_prog |-> !prot(mem_addr, protect_level)) else $error("protected program");
    a_erase_open:
        assert property (mem_erase |-> !prot(mem_addr, protect_level)) else $error("protected erase");
    a_oe_release:
        assert property (cs_n [*5] |-> !so_oe) else $error("output driven while deselected");
    a_latch_set:
        assert property ($rose(write_enable_latch) |-> cs_n && !$past(busy))
        else $error("latch set at wrong time");
    a_lock_hold:
        assert property (!$stable({protect_lock, protect_level}) |-> !($past(protect_lock) &&
            !$past(write_protect_n, 2) && !$past(write_protect_n, 3) && !$past(write_protect_n, 4)))
        else $error("locked protection changed");
endmodule // flash_engine_props
`default_nettype wire

// File: test/spi_host_model.sv
// Purpose: host side of the serial link
// Assumes: 800 ns link clock, idle low outside frames
// Notes:   launches on the low phase, samples at the rise
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // clock and returned data
    input wire logic ref_clk,
    input wire logic so_line,
    // link pins
    output var logic cs_n,
    output var logic sck,
    output var logic si
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    task automatic sel();
        @(posedge ref_clk);
        #1 cs_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    // release: data line shows the inverse, instruction runs now
    task automatic desel();
        @(posedge ref_clk);
        #1 cs_n = 1'b1;
        si = ~si;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    // nb bits, msb first, four ref_clk per phase
    task automatic shift(input logic [7:0] b, input int nb, output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < nb; i++) begin
            si = b[7 - i];
            repeat (4) @(posedge ref_clk);
            #1 sck = 1'b1;
            r = {r[6:0], so_line};
            repeat (4) @(posedge ref_clk);
            #1 sck = 1'b0;
        end
    endtask
endmodule // spi_host_model
`default_nettype wire

// File: test/tb.sv
// Purpose: instruction level test of the flash command engine
// Assumes: shortened erase counts, byte program count left at its default of 200
// Notes:   array stand-in returns a fixed address pattern
`timescale 1ns/1ps
`default_nettype none
`include "serial_flash_defs.vh"
module tb;
    localparam [`TMR_W-1:0] BP = 200, SE = 40, BE = 40, CE = 60;
    logic ref_clk, rst_n, clk_en, write_protect_n;
    logic [7:0] mem_rdata, last_d, rx [0:3];
    logic [`ADDR_W-1:0] last_a;
    logic [1:0] last_k;
    wire cs_n, sck, si, so_out, so_oe, mem_rd, mem_prog, mem_erase, busy, latch, autop, lock;
    wire [`ADDR_W-1:0] mem_addr;
    wire [7:0] mem_wdata;
    wire [1:0] mem_erase_kind, lvl;
    int n_errors = 0, checks = 0, n_prog = 0, n_erase = 0;
    serial_flash_command_engine #(.BYTE_PROG_CYC(BP), .SECT_ERASE_CYC(SE), .BLK_ERASE_CYC(BE),
        .CHIP_ERASE_CYC(CE)) serial_flash_command_engine_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(clk_en), .cs_n(cs_n), .sck(sck), .si(si), .write_protect_n(write_protect_n),
        .so_out(so_out), .so_oe(so_oe), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_prog(mem_prog), .mem_erase(mem_erase),
        .mem_erase_kind(mem_erase_kind), .busy(busy), .write_enable_latch(latch),
        .auto_increment_program(autop), .protect_level(lvl), .protect_lock(lock));
    spi_host_model spi_host_model_inst (.ref_clk(ref_clk), .so_line(so_oe ? so_out : ~si),
        .cs_n(cs_n), .sck(sck), .si(si));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    function automatic logic [7:0] pat(input logic [`ADDR_W-1:0] a);
        pat = a[7:0] ^ 8'hC3 ^ {6'h00, a[17:16]};
    endfunction
    // array stand-in: data a cycle after the strobe, logs writes
    always @(posedge ref_clk) begin
        if (mem_rd) mem_rdata <= pat(mem_addr);
        if (mem_prog) begin
            n_prog++;
            last_a <= mem_addr;
            last_d <= mem_wdata;
        end
        if (mem_erase) begin
            n_erase++;
            last_a <= mem_addr;
            last_k <= mem_erase_kind;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one frame: n bytes from the top of b, last one nb bits, then nr bytes read
    task automatic op(input int n, input logic [39:0] b, input int nr = 0, input int nb = 8);
        logic [7:0] r;
        spi_host_model_inst.sel();
        for (int i = 0; i < n; i++)
            spi_host_model_inst.shift(b[39 - 8 * i -: 8], (i == n - 1) ? nb : 8, r);
        for (int i = 0; i < nr; i++) begin
            spi_host_model_inst.shift(8'h00, 8, r);
            rx[i] = r;
        end
        spi_host_model_inst.desel();
    endtask
    task automatic wr_stat(input logic [7:0] d);
        op(1, 40'h5000000000);
        op(2, {8'h01, d, 24'h000000});
    endtask
    task automatic idle();
        repeat (300) if (busy === 1'b1) @(posedge ref_clk);
        #1 chk(busy, 0);
    endtask
    task automatic end_sim();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #5_000_000;
        n_errors++;
        end_sim();
    end
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        write_protect_n = 1'b1;
        mem_rdata = 8'h00;
        repeat (20) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 chk({lock, lvl, latch, autop}, 5'h0C);
        op(1, 40'h0500000000, 2);
        chk({rx[0], rx[1]}, 16'h0C0C);
        op(1, 40'h0600000000);
        chk(latch, 1);
        op(1, 40'h0400000000, 0, 4);
        chk(latch, 1);
        op(1, 40'h0400000000);
        chk(latch, 0);
        op(1, 40'h0600000000);
        op(5, 40'h020000105A);
        chk(n_prog, 0);
        op(2, 40'h0100000000);
        chk(lvl, 3);
        op(1, 40'h5000000000);
        op(1, 40'h0500000000, 1);
        op(2, 40'h0100000000);
        chk(lvl, 3);
        wr_stat(8'h04);
        chk(lvl, 1);
        op(1, 40'h0400000000);
        op(5, 40'h020000105A);
        chk(n_prog, 0);
        op(1, 40'h0600000000);
        op(5, 40'h020000105A);
        chk({busy, n_prog[4:0], last_a, last_d}, {6'h21, 18'h00010, 8'h5A});
        op(1, 40'h0600000000);
        op(1, 40'h0500000000, 1);
        chk(rx[0], 8'h07);
        idle();
        chk(latch, 0);
        op(4, 40'h0303FFFF00, 3);
        chk({rx[0], rx[1], rx[2]}, {pat(18'h3FFFF), pat(0), pat(1)});
        op(4, 40'h9000000100, 2);
        chk({rx[0], rx[1]}, {`PART_CODE, `MAKER_CODE});
        op(4, 40'hAB00000000, 2);
        chk({rx[0], rx[1]}, {`MAKER_CODE, `PART_CODE});
        op(1, 40'h0600000000);
        op(4, 40'h2001234500);
        chk({n_erase[3:0], last_a[17:12], last_k}, {4'h1, 6'h12, `ERASE_SECTOR});
        idle();
        op(1, 40'h0600000000);
        op(4, 40'h5202ABCD00);
        chk({n_erase[3:0], last_a[17:15], last_k}, {4'h2, 3'h5, `ERASE_BLOCK});
        idle();
        op(1, 40'h0600000000);
        op(4, 40'h2003100000);
        op(1, 40'h6000000000);
        chk(n_erase, 2);
        op(3, 40'h0200000000);
        chk(n_prog, 1);
        op(1, 40'h0600000000);
        op(5, 40'hAF02FFFE11);
        chk(autop, 1);
        idle();
        op(2, 40'hAF22000000);
        idle();
        chk({n_prog[5:0], last_a, last_d}, {6'h03, 18'h2FFFF, 8'h22});
        chk({autop, latch}, 0);
        op(1, 40'h0600000000);
        op(5, 40'hAF03000033);
        chk(n_prog, 3);
        op(5, 40'hAF00010044);
        idle();
        chk({n_prog[7:0], autop}, 9'h009);
        op(1, 40'h0400000000);
        chk({autop, latch}, 0);
        wr_stat(8'h00);
        op(1, 40'h0600000000);
        op(1, 40'h6000000000);
        chk({n_erase[3:0], last_k}, {4'h3, `ERASE_CHIP});
        idle();
        write_protect_n = 1'b0;
        wr_stat(8'h8C);
        chk({lock, lvl}, 3'h7);
        wr_stat(8'h00);
        chk({lock, lvl}, 3'h7);
        write_protect_n = 1'b1;
        wr_stat(8'h00);
        chk({lock, lvl}, 3'h0);
        end_sim();
    end
endmodule // tb
bind serial_flash_command_engine flash_engine_props #(.BYTE_PROG_CYC(BYTE_PROG_CYC),
    .SECT_ERASE_CYC(SECT_ERASE_CYC), .BLK_ERASE_CYC(BLK_ERASE_CYC),
    .CHIP_ERASE_CYC(CHIP_ERASE_CYC)) props_inst (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n),
    .write_protect_n(write_protect_n), .so_oe(so_oe), .mem_addr(mem_addr), .mem_prog(mem_prog),
    .mem_erase(mem_erase), .mem_erase_kind(mem_erase_kind), .protect_level(protect_level),
    .busy(busy), .write_enable_latch(write_enable_latch), .protect_lock(protect_lock));
`default_nettype wire
